// ==== verilog/asv_consts.svh ====
// Constants for the startup level register bank.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ASV_CONSTS_SVH
`define ASV_CONSTS_SVH
`define ASV_OFFSET        8'hEB
`define ASV_RESET_VALUE   16'h01F4
`define ASV_LEVEL_W       10
`define ASV_LEVEL_MSB     9
`define ASV_LSB_MV        2
`define ASV_SUPPORT_MIN   10'h0FA
`define ASV_SUPPORT_MAX   10'h2EE
`endif

// ==== verilog/asv_pkg.sv ====
// Types for the startup level register bank.
// Assumes no surroundings beyond the constants header.
`include "asv_consts.svh"
package asv_pkg;
  // Channel operating mode
  typedef enum logic [1:0] {
    ASV_MODE_PMBUS,
    ASV_MODE_A,
    ASV_MODE_AVS
  } asv_mode_t;
endpackage

// ==== verilog/asv_startup_level.sv ====
// Paged startup level register for the AVS reference DAC.
// Assumes a PMBus front end that presents decoded single-cycle
// command strobes, and an NVM engine that presents restore strobes.
`timescale 1ns/1ns
`default_nettype none
`include "asv_consts.svh"
module asv_startup_level #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // Command access
  input  wire logic [7:0]                 cmd_code,
  input  wire logic                       cmd_write,
  input  wire logic                       cmd_read,
  input  wire logic [15:0]                cmd_wdata,
  input  wire logic [$clog2(CHANNELS)-1:0] page,
  output logic      [15:0]                cmd_rdata,
  output logic                            cmd_ack,
  // NVM restore
  input  wire logic                       nvm_restore,
  input  wire logic [15:0]                nvm_data,
  input  wire logic [$clog2(CHANNELS)-1:0] nvm_page,
  // Per-channel mode and limits
  input  wire asv_pkg::asv_mode_t         mode [CHANNELS],
  input  wire logic [9:0]                 avs_upper_limit [CHANNELS],
  input  wire logic [9:0]                 avs_lower_limit [CHANNELS],
  input  wire logic [CHANNELS-1:0]        startup_event,
  // DAC side
  output logic      [9:0]                 dac_code [CHANNELS],
  output logic      [CHANNELS-1:0]        dac_load,
  output logic      [15:0]                dac_mv [CHANNELS],
  // Status
  input  wire logic                       status_clear,
  output logic                            status_oth,
  output logic                            status_ivd,
  output logic                            status_cml,
  output logic                            smbalert_n
);

  // ******************************
  // Reset release
  // ******************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ******************************
  // Access decode
  // ******************************
  logic        hit;
  logic        wr_hit;
  logic        wr_blocked;
  logic        wr_range_bad;
  logic [9:0]  wr_level;
  logic [9:0]  nvm_level;
  logic [9:0]  lim_hi;
  logic [9:0]  lim_lo;

  assign hit      = (cmd_code == `ASV_OFFSET);
  assign wr_hit   = hit && cmd_write;
  assign wr_level  = cmd_wdata[`ASV_LEVEL_MSB:0];
  assign nvm_level = nvm_data[`ASV_LEVEL_MSB:0];
  assign wr_blocked   = (mode[page] == asv_pkg::ASV_MODE_AVS);
  // window held to support
  // A loose limit pair must not widen the window past the support range.
  assign lim_hi = (avs_upper_limit[page] > `ASV_SUPPORT_MAX) ? `ASV_SUPPORT_MAX
                                                             : avs_upper_limit[page];
  assign lim_lo = (avs_lower_limit[page] < `ASV_SUPPORT_MIN) ? `ASV_SUPPORT_MIN
                                                             : avs_lower_limit[page];
  assign wr_range_bad = (wr_level > lim_hi)
                     || (wr_level < lim_lo);

  assign cmd_ack = hit && (cmd_write || cmd_read);

  // ******************************
  // Per-channel storage
  // ******************************
  logic [9:0] level [CHANNELS];

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          level[g] <= 10'(`ASV_RESET_VALUE);
        end else if (wr_hit && page == g && !wr_blocked && !wr_range_bad) begin
          level[g] <= wr_level;
        end else if (nvm_restore && nvm_page == g
                     && mode[g] != asv_pkg::ASV_MODE_AVS) begin
          level[g] <= nvm_level;
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          dac_code[g] <= 10'(`ASV_RESET_VALUE);
          dac_load[g] <= 1'b0;
        end else begin
          dac_load[g] <= startup_event[g] && mode[g] != asv_pkg::ASV_MODE_PMBUS;
          if (startup_event[g] && mode[g] != asv_pkg::ASV_MODE_PMBUS) begin
            dac_code[g] <= level[g];
          end
        end
      end

      assign dac_mv[g] = 16'(dac_code[g] * `ASV_LSB_MV);
    end
  endgenerate

  // ******************************
  // Read data
  // ******************************
  // high bits read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata <= 16'h0000;
    end else if (hit && cmd_read) begin
      cmd_rdata <= {6'h00, level[page]};
    end
  end

  // ******************************
  // Fault flags
  // ******************************
  // Set wins over clear so a fault in the clear cycle survives.
  // oth on blocked write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_oth <= 1'b0;
    end else if (wr_hit && wr_blocked) begin
      status_oth <= 1'b1;
    end else if (status_clear) begin
      status_oth <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ivd <= 1'b0;
    end else if (wr_hit && !wr_blocked && wr_range_bad) begin
      status_ivd <= 1'b1;
    end else if (status_clear) begin
      status_ivd <= 1'b0;
    end
  end

  assign status_cml = status_oth || status_ivd;
  assign smbalert_n = !status_cml;

  // ******************************
  // Checks
  // ******************************
  property p_blocked_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && wr_blocked && !nvm_restore |=> level[$past(page)] == $past(level[page]);
  endproperty
  a_blocked_keep: assert property (p_blocked_keep) else $error("blocked write changed level");

  property p_oth_set;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && wr_blocked |=> status_oth && !smbalert_n;
  endproperty
  a_oth_set: assert property (p_oth_set) else $error("oth not raised");

  property p_ack;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit |-> cmd_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("write not acked");

  property p_ivd_set;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && !wr_blocked && wr_range_bad |=> status_ivd && status_cml;
  endproperty
  a_ivd_set: assert property (p_ivd_set) else $error("ivd not raised");

  property p_good_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && !wr_blocked && !wr_range_bad |=> level[$past(page)] == $past(wr_level);
  endproperty
  a_good_write: assert property (p_good_write) else $error("write not stored");

  sequence s_start;
    startup_event[0] && mode[0] != asv_pkg::ASV_MODE_PMBUS;
  endsequence
  property p_dac_load;
    @(posedge ref_clk) disable iff (!rst_n)
    s_start |=> dac_load[0] && dac_code[0] == $past(level[0]);
  endproperty
  a_dac_load: assert property (p_dac_load) else $error("dac not loaded");

  property p_read_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    hit && cmd_read |=> cmd_rdata[15:10] == 6'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("high bits nonzero");

  property p_mv;
    @(posedge ref_clk) disable iff (!rst_n)
    dac_load[0] |-> dac_mv[0] == {5'h00, dac_code[0], 1'b0};
  endproperty
  a_mv: assert property (p_mv) else $error("mv scale wrong");

  // Read returns the paged copy
  property p_read_data;
    @(posedge ref_clk) disable iff (!rst_n)
    hit && cmd_read |=> cmd_rdata[9:0] == $past(level[page]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  // Restore into a channel in AVS mode
  sequence s_nvm_avs;
    nvm_restore && mode[nvm_page] == asv_pkg::ASV_MODE_AVS && !wr_hit;
  endsequence
  property p_nvm_blocked;
    @(posedge ref_clk) disable iff (!rst_n)
    s_nvm_avs |=> level[$past(nvm_page)] == $past(level[nvm_page]);
  endproperty
  a_nvm_blocked: assert property (p_nvm_blocked) else $error("restore in AVS");

  // Restore with no competing host write
  sequence s_nvm_ok;
    nvm_restore && mode[nvm_page] != asv_pkg::ASV_MODE_AVS
    && !(wr_hit && page == nvm_page);
  endsequence
  property p_nvm_load;
    @(posedge ref_clk) disable iff (!rst_n)
    s_nvm_ok |=> level[$past(nvm_page)] == $past(nvm_level);
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("restore not stored");

  // Accepted host write
  sequence s_good_wr;
    wr_hit && !wr_blocked && !wr_range_bad;
  endsequence
  property p_support;
    @(posedge ref_clk) disable iff (!rst_n)
    s_good_wr |-> wr_level >= `ASV_SUPPORT_MIN && wr_level <= `ASV_SUPPORT_MAX;
  endproperty
  a_support: assert property (p_support) else $error("level out of support");

  // Sticky flag without a clear
  property p_oth_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    status_oth && !status_clear |=> status_oth;
  endproperty
  a_oth_hold: assert property (p_oth_hold) else $error("oth dropped");

  // Startup in plain mode leaves DAC alone
  sequence s_start_plain;
    startup_event[0] && mode[0] == asv_pkg::ASV_MODE_PMBUS;
  endsequence
  property p_no_load;
    @(posedge ref_clk) disable iff (!rst_n)
    s_start_plain |=> !dac_load[0] && $stable(dac_code[0]);
  endproperty
  a_no_load: assert property (p_no_load) else $error("dac loaded in plain mode");

  // Blocked write leaves ivd alone
  property p_blocked_no_ivd;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit && wr_blocked && !status_ivd |=> !status_ivd;
  endproperty
  a_blocked_no_ivd: assert property (p_blocked_no_ivd) else $error("ivd on blocked");

endmodule
`default_nettype wire

// ==== bench/asv_host.sv ====
// Host model driving the command side of the startup level bank.
// Assumes the bench calls acc just after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module asv_host (
  // Clock and answer
  input  wire logic        ref_clk,
  input  wire logic        cmd_ack,
  // Command strobes
  output logic      [7:0]  cmd_code,
  output logic             cmd_write,
  output logic             cmd_read,
  output logic      [15:0] cmd_wdata
);
  initial begin
    cmd_code = 8'h00;
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    cmd_wdata = 16'h0000;
  end
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                     output logic a);
    cmd_code <= c;
    cmd_write <= w;
    cmd_read <= !w;
    cmd_wdata <= d;
    #20 a = cmd_ack;
    @(negedge ref_clk);
    cmd_write <= 1'b0;
    cmd_read <= 1'b0;
    // Released lines show garbage, not the old value
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    // Idle cycle so a following call never reassigns in this step
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the startup level register bank.
// Assumes the host model in asv_host.sv and two channels.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk, resetn, nvm_restore, status_clear, cmd_ack, a;
  logic status_oth, status_ivd, status_cml, smbalert_n;
  logic cmd_write, cmd_read, page, nvm_page;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, nvm_data, dac_mv [2];
  logic [9:0] avs_upper_limit [2], avs_lower_limit [2], dac_code [2];
  logic [1:0] startup_event, dac_load;
  logic [15:0] bnd [4] = '{16'h00F9, 16'h00FA, 16'h02EE, 16'h02EF};
  asv_pkg::asv_mode_t mode [2];
  int lvl [2], errors, n_tests, s;
  asv_startup_level #(.CHANNELS(2)) asv_startup_level_i (.*);
  asv_host asv_host_i (.*);
  // **********
  // Checks and accesses
  // **********
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic p, input logic [15:0] d);
    logic o, v;
    page = p;
    o = mode[p] == asv_pkg::ASV_MODE_AVS;
    v = !o && (d[9:0] < avs_lower_limit[p] || d[9:0] > avs_upper_limit[p]
               || d[9:0] < 250 || d[9:0] > 750);
    if (!o && !v) lvl[p] = d[9:0];
    asv_host_i.acc(1'b1, 8'hEB, d, a);
    chk(a, 1'b1);
    chk({status_oth, status_ivd, status_cml, smbalert_n}, {o, v, o | v, !(o | v)});
    status_clear <= 1'b1;
    @(negedge ref_clk) status_clear <= 1'b0;
  endtask
  task automatic rd(input logic p);
    page = p;
    asv_host_i.acc(1'b0, 8'hEB, 16'h0000, a);
    chk(a, 1'b1);
    chk(cmd_rdata, lvl[p]);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Far beyond the hundred or so cycles the run needs
  initial begin
    #2000000;
    errors++;
    summarize();
  end
  initial begin
    s = $urandom(84243);
    {resetn, nvm_restore, status_clear, page, nvm_page, nvm_data, startup_event} = '0;
    mode = '{default: asv_pkg::ASV_MODE_PMBUS};
    avs_lower_limit = '{default: 10'h0FA};
    avs_upper_limit = '{default: 10'h2EE};
    lvl = '{default: 500};
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    asv_host_i.acc(1'b0, 8'hEA, 16'h0000, a);
    chk(a, 1'b0);
    for (int i = 0; i < 6; i++) begin
      mode[0] = asv_pkg::asv_mode_t'(i % 3);
      rd(i % 2);
      wr(0, 16'($urandom_range(750, 250)) | 16'hFC00);
      wr(1, 16'($urandom));
      rd(0);
    end
    for (int i = 0; i < 4; i++) wr(1, bnd[i]);
    rd(1);
    nvm_data = 16'h0123;
    for (int p = 0; p < 2; p++) begin
      nvm_page = p;
      nvm_restore = 1'b1;
      @(negedge ref_clk) nvm_restore = 1'b0;
      if (p == 1) lvl[1] = 10'h123;
      rd(p);
    end
    for (int m = 0; m < 3; m++) begin
      mode[1] = asv_pkg::asv_mode_t'(m);
      startup_event = 2'b11;
      @(negedge ref_clk) startup_event = 2'b00;
      chk(dac_load, {m != 0, 1'b1});
      chk(dac_code[1], m ? lvl[1] : 500);
      chk(dac_mv[0], lvl[0] * 2);
    end
    summarize();
  end
endmodule
`default_nettype wire
